// ==== rtl/tcm_pkg.sv ====
// Package for the timer capture/match register block.
// Assumes a single 40 MHz core clock and a plain register port.
package tcm_pkg;

  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [31:0] TCM_BASE_ADDR = 32'h40014000;
  localparam logic [31:0] TCM_CMP0_ADDR = 32'h40014018;
  localparam logic [31:0] TCM_CMP1_ADDR = 32'h4001401C;
  localparam logic [31:0] TCM_CMP2_ADDR = 32'h40014020;
  localparam logic [31:0] TCM_CMP3_ADDR = 32'h40014024;
  localparam logic [31:0] TCM_CEC_ADDR = 32'h40014028;
  localparam logic [31:0] TCM_CAP0_ADDR = 32'h4001402C;
  localparam logic [31:0] TCM_CAP1_ADDR = 32'h40014030;
  localparam logic [31:0] TCM_IRQ_STAT_ADDR = 32'h40014040;
  localparam logic [31:0] TCM_IRQ_MASK_ADDR = 32'h40014044;

  // ****************************************
  // Capture control fields
  // ****************************************
  localparam int TCM_CEC_IN0_RISE = 0;
  localparam int TCM_CEC_IN0_FALL = 1;
  localparam int TCM_CEC_IN0_IRQ = 2;
  localparam int TCM_CEC_IN1_RISE = 3;
  localparam int TCM_CEC_IN1_FALL = 4;
  localparam int TCM_CEC_IN1_IRQ = 5;
  localparam int TCM_CEC_W = 6;

  // Status/mask layout: bits 3:0 match events, bits 5:4 capture events
  localparam int TCM_ST_MATCH0 = 0;
  localparam int TCM_ST_CAP0 = 4;
  localparam int TCM_ST_W = 6;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] TCM_CMP_RST = 32'h00000000;
  localparam logic [31:0] TCM_CAP_RST = 32'h00000000;
  localparam logic [5:0] TCM_CEC_RST = 6'h00;
  localparam logic [5:0] TCM_IRQ_RST = 6'h00;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } tcm_bus_req_t;

  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
  } tcm_edge_state_t;

endpackage

// ==== rtl/tcm_edge_det.sv ====
// Capture pin synchroniser and edge finder for two inputs.
// Assumes pins are asynchronous to core_clk in the worst case.
`timescale 1ns/1ps
`default_nettype none
module tcm_edge_det
  import tcm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Pins
  input wire logic [1:0] pin_in,
  // Edge pulses
  output logic [1:0] rise_pls,
  output logic [1:0] fall_pls
);

  tcm_edge_state_t st_ff;
  tcm_edge_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync1 = pin_in;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.prev = st_ff.sync2;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Only sync2 and prev are compared; sync1 feeds sync2 alone
  assign rise_pls = st_ff.sync2 & ~st_ff.prev;
  assign fall_pls = ~st_ff.sync2 & st_ff.prev;

endmodule
`default_nettype wire

// ==== rtl/tcm_regs.sv ====
// Capture control, capture and compare registers of one timer.
// Assumes timer_count comes from the counter in the same clock domain.
`timescale 1ns/1ps
`default_nettype none

module tcm_regs
  import tcm_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Timer
  input wire logic [31:0] timer_count,
  output logic [3:0] match_hit,
  // Capture pins
  input wire logic capture_input_0,
  input wire logic capture_input_1,
  // Interrupt
  output logic irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [3:0][31:0] compare_value;
    logic [1:0][31:0] captured_value;
    logic [5:0] cec;
    logic [5:0] irq_stat;
    logic [5:0] irq_mask;
    logic [3:0] match_q;
    logic [31:0] rdata;
  } tcm_regs_state_t;

  tcm_regs_state_t st_ff;
  tcm_regs_state_t nxt_st;
  tcm_bus_req_t req;
  logic [1:0] rise_pls;
  logic [1:0] fall_pls;
  logic [1:0] cap_evt;
  logic [1:0] cap_irq_en;
  logic [3:0] match_now;
  logic [3:0] match_evt;
  logic [5:0] set_bits;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  tcm_edge_det u_edge (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pin_in({capture_input_1, capture_input_0}),
    .rise_pls(rise_pls),
    .fall_pls(fall_pls)
  );

  // ****************************************
  // Capture events
  // ****************************************
  always_comb begin
    // Either enabled edge counts; both set means every transition
    cap_evt[0] = (rise_pls[0] & st_ff.cec[TCM_CEC_IN0_RISE])
               | (fall_pls[0] & st_ff.cec[TCM_CEC_IN0_FALL]);
    cap_evt[1] = (rise_pls[1] & st_ff.cec[TCM_CEC_IN1_RISE])
               | (fall_pls[1] & st_ff.cec[TCM_CEC_IN1_FALL]);
    cap_irq_en[0] = st_ff.cec[TCM_CEC_IN0_IRQ];
    cap_irq_en[1] = st_ff.cec[TCM_CEC_IN1_IRQ];
  end

  // ****************************************
  // Match compare
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_match
      assign match_now[gi] = (st_ff.compare_value[gi] == timer_count);
    end
  endgenerate

  // Event on entry to equality so a held count raises one event
  assign match_evt = match_now & ~st_ff.match_q;
  assign match_hit = match_now;

  assign set_bits = {cap_evt & cap_irq_en, match_evt};

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.match_q = match_now;
    nxt_st.rdata = 32'h00000000;
    if (req.wr) begin
      unique case (req.addr)
        TCM_CMP0_ADDR: nxt_st.compare_value[0] = req.wdata;
        TCM_CMP1_ADDR: nxt_st.compare_value[1] = req.wdata;
        TCM_CMP2_ADDR: nxt_st.compare_value[2] = req.wdata;
        TCM_CMP3_ADDR: nxt_st.compare_value[3] = req.wdata;
        TCM_CEC_ADDR: nxt_st.cec = req.wdata[5:0];
        TCM_IRQ_STAT_ADDR: nxt_st.irq_stat = st_ff.irq_stat & ~req.wdata[5:0];
        TCM_IRQ_MASK_ADDR: nxt_st.irq_mask = req.wdata[5:0];
        default: begin
        end
      endcase
    end
    // Set after clear so a coincident event is kept
    nxt_st.irq_stat = nxt_st.irq_stat | set_bits;
    if (cap_evt[0]) begin
      nxt_st.captured_value[0] = timer_count;
    end
    if (cap_evt[1]) begin
      nxt_st.captured_value[1] = timer_count;
    end
    if (req.rd) begin
      unique case (req.addr)
        TCM_CMP0_ADDR: nxt_st.rdata = st_ff.compare_value[0];
        TCM_CMP1_ADDR: nxt_st.rdata = st_ff.compare_value[1];
        TCM_CMP2_ADDR: nxt_st.rdata = st_ff.compare_value[2];
        TCM_CMP3_ADDR: nxt_st.rdata = st_ff.compare_value[3];
        // Reserved bits are free to read as anything; zero is simplest
        TCM_CEC_ADDR: nxt_st.rdata = {26'h0000000, st_ff.cec};
        TCM_CAP0_ADDR: nxt_st.rdata = st_ff.captured_value[0];
        TCM_CAP1_ADDR: nxt_st.rdata = st_ff.captured_value[1];
        TCM_IRQ_STAT_ADDR: nxt_st.rdata = {26'h0000000, st_ff.irq_stat};
        TCM_IRQ_MASK_ADDR: nxt_st.rdata = {26'h0000000, st_ff.irq_mask};
        default: nxt_st.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_ff.compare_value <= {4{TCM_CMP_RST}};
      st_ff.captured_value <= {2{TCM_CAP_RST}};
      st_ff.cec <= TCM_CEC_RST;
      st_ff.irq_stat <= TCM_IRQ_RST;
      st_ff.irq_mask <= TCM_IRQ_RST;
      st_ff.match_q <= 4'h0;
      st_ff.rdata <= 32'h00000000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign irq = |(st_ff.irq_stat & st_ff.irq_mask);

endmodule
`default_nettype wire

// ==== bench/tcm_chk_asserts.sv ====
// Checker of the tcm_regs ports, bound at the foot.
// Assumes shadows of written registers are enough.
`timescale 1ns/1ps
`default_nettype none
module tcm_chk
  import tcm_pkg::*;
(
  // Watched ports
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [31:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [31:0] timer_count,
  input wire logic [3:0] match_hit,
  input wire logic capture_input_0,
  input wire logic capture_input_1,
  input wire logic irq
);
  logic [31:0] cmp_ff;
  logic [5:0] cec_ff;
  logic [5:0] msk_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ****
  // Shadows, compare 0 only to keep it small
  // ****
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cmp_ff <= 32'h0;
      cec_ff <= 6'h0;
      msk_ff <= 6'h0;
    end else if (reg_wr && reg_addr == TCM_CMP0_ADDR) begin
      cmp_ff <= reg_wdata;
    end else if (reg_wr && reg_addr == TCM_CEC_ADDR) begin
      cec_ff <= reg_wdata[5:0];
    end else if (reg_wr && reg_addr == TCM_IRQ_MASK_ADDR) begin
      msk_ff <= reg_wdata[5:0];
    end
  end
  property p_cap(ev, b, i);
    ev && cec_ff[b] && cec_ff[3*i+2] && msk_ff[4+i] |-> ##[2:5] irq;
  endproperty
  chk_cmp_read: assert property (reg_rd && reg_addr == TCM_CMP0_ADDR |=> reg_rdata == $past(cmp_ff))
    else $error("cmp read");
  chk_cec_read: assert property (reg_rd && reg_addr == TCM_CEC_ADDR |=> reg_rdata[5:0] == $past(cec_ff))
    else $error("cec read");
  chk_match_live: assert property (match_hit[0] == (cmp_ff == timer_count))
    else $error("match");
  chk_in0_rise: assert property (p_cap($rose(capture_input_0), 0, 0))
    else $error("in0 rise");
  chk_in0_fall: assert property (p_cap($fell(capture_input_0), 1, 0))
    else $error("in0 fall");
  chk_in1_rise: assert property (p_cap($rose(capture_input_1), 3, 1))
    else $error("in1 rise");
  chk_in1_fall: assert property (p_cap($fell(capture_input_1), 4, 1))
    else $error("in1 fall");
  chk_irq_mask: assert property (irq |-> (msk_ff | $past(msk_ff)) != 6'h0)
    else $error("irq unmasked");
  cover property ($rose(irq));
  cover property (match_hit[0] && cmp_ff != 32'h0);
  cover property (reg_rd && reg_addr == TCM_CAP1_ADDR);
endmodule
bind tcm_regs tcm_chk u_chk (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .timer_count, .match_hit, .capture_input_0, .capture_input_1, .irq);
`default_nettype wire

// ==== bench/tcm_far.sv ====
// Far side: free-running timer count and capture pins.
// Assumes the bench asks for pin levels.
`timescale 1ns/1ps
`default_nettype none
module tcm_far (
  // Clock, reset, request, outputs
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [1:0] pin_req,
  output logic [31:0] timer_count,
  output logic [1:0] pin
);
  // Pins lag a cycle, like board lines
  always_ff @(posedge core_clk) begin
    pin <= pin_req;
    timer_count <= sys_rst ? 32'h0 : timer_count + 32'h1;
  end
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for tcm_regs.
// Assumes tcm_far supplies the count and the pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import tcm_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic irq;
  logic [31:0] reg_addr = 32'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata, timer_count, v, a;
  logic [31:0] cap_exp [2] = '{32'h0, 32'h0};
  logic [31:0] cmp_exp [4] = '{32'h0, 32'h0, 32'h0, 32'h0};
  logic [1:0] pin_req = 2'h0;
  logic [1:0] pin;
  logic [3:0] match_hit;
  logic [5:0] cfg [8] = '{6'h05, 6'h06, 6'h03, 6'h04, 6'h28, 6'h30, 6'h38, 6'h20};
  int i, err_count = 0, samples_checked = 0;
  initial forever #12.5 core_clk = ~core_clk;
  tcm_far u_far (.core_clk, .sys_rst, .pin_req, .timer_count, .pin);
  tcm_regs DUT (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .timer_count,
    .match_hit, .capture_input_0(pin[0]), .capture_input_1(pin[1]), .irq);
  // Status bit needs an enabled edge and the capture interrupt enable
  function automatic logic irq_exp(logic [5:0] c, int n);
    return (|c[3*n +: 2]) & c[3*n+2];
  endfunction
  function automatic logic [3:0] match_exp(logic [31:0] t);
    logic [3:0] m;
    for (int k = 0; k < 4; k++) begin
      m[k] = (cmp_exp[k] == t);
    end
    return m;
  endfunction
  task automatic check(string n, logic [31:0] e, logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(logic [31:0] ad, logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [31:0] ad, logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check("rdata", e, reg_rdata);
  endtask
  // Capture lands two counts after the pin moves
  task automatic pulse(int n, logic lvl, logic en);
    @(posedge core_clk);
    pin_req[n] <= lvl;
    @(posedge core_clk);
    #1 v = timer_count + 32'h2;
    repeat (6) @(posedge core_clk);
    if (en) cap_exp[n] = v;
    rd(TCM_CAP0_ADDR + 32'(4 * n), cap_exp[n]);
  endtask
  task automatic match_chk();
    @(posedge core_clk);
    #1 check("match_hit", {28'h0, match_exp(timer_count)}, {28'h0, match_hit});
  endtask
  task automatic irq_chk(logic e);
    repeat (3) @(posedge core_clk);
    #1 check("irq", {31'h0, e}, {31'h0, irq});
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (4000) @(posedge core_clk);
    err_count++;
    test_done();
  end
  initial begin
    void'($urandom(72636));
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(TCM_CEC_ADDR, 32'h0);
    rd(TCM_CAP0_ADDR, 32'h0);
    rd(TCM_CAP1_ADDR, 32'h0);
    for (int k = 0; k < 4; k++) begin
      a = TCM_CMP0_ADDR + 32'(4 * k);
      v = (k == 3) ? 32'hFFFFFFFF : $urandom;
      rd(a, 32'h0);
      wr(a, v);
      cmp_exp[k] = v;
      rd(a, v);
    end
    // Count is settled here; match lands well inside the window
    v = timer_count + 32'h14;
    wr(TCM_IRQ_STAT_ADDR, 32'h3F);
    wr(TCM_CMP0_ADDR, v);
    cmp_exp[0] = v;
    repeat (30) match_chk();
    rd(TCM_IRQ_STAT_ADDR, 32'h1);
    wr(32'h40014050, 32'hFFFFFFFF);
    rd(32'h40014050, 32'h0);
    wr(TCM_IRQ_MASK_ADDR, 32'h30);
    foreach (cfg[k]) begin
      i = k / 4;
      wr(TCM_CEC_ADDR, {26'h0, cfg[k]});
      rd(TCM_CEC_ADDR, {26'h0, cfg[k]});
      pulse(i, 1'b1, cfg[k][3*i]);
      pulse(i, 1'b0, cfg[k][3*i+1]);
      irq_chk(irq_exp(cfg[k], i));
      wr(TCM_IRQ_MASK_ADDR, 32'h0);
      irq_chk(1'b0);
      wr(TCM_IRQ_STAT_ADDR, 32'h3F);
      wr(TCM_IRQ_MASK_ADDR, 32'h30);
      irq_chk(1'b0);
    end
    test_done();
  end
endmodule
`default_nettype wire
